// [logic/adsr_flag.sv]
// Purpose: one sticky status flag
// Assumes: set and clr are one-cycle strobes on aclk
// Notes: set wins over a clear in the same cycle
`timescale 1ns/10ps
module adsr_flag
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic set,
	input wire logic clr,
	output logic q
);
	// an event landing on the clear cycle must not be lost
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			q <= 1'b0;
		else if (set)
			q <= 1'b1;
		else if (clr)
			q <= 1'b0;
	end
endmodule // adsr_flag

// [logic/adsr_pkg.sv]
// Purpose: constants for the adc sequence repeat and step controller
// Assumes: 100 MHz aclk, AXI4-Lite register access, 32-bit data
// Notes: offsets are byte addresses of aligned words
// Summary of operation
// - mode 5 converts the whole selected slot set pass after pass
// - pass count comes from repeat count field; default gives one pass
// - passes performed equal repeat count plus one; 10 gives 11
// - once started, mode 5 keeps converting slots in order until done
// - each conversion sets end-of-conversion and stores result by slot index
// - with sum enable set, every result is added into the sum register too
// - each finished pass sets sequence done, then next pass if needed
// - last pass sets all-passes-done, clears start itself and stops
// - mode 6 converts only the current slot per start
// - mode 6 slot done sets eoc, stores result, clears start, waits
// - mode 6 next start converts the channel of the following slot
// - mode 6 after slot 7 the next slot is slot 0
// - mode 6 sets sequence done only after all selected slots converted
// - slot count select picks slots 0 through its value; the mode 6 pointer still runs on to slot 7
// - each slot channel field names the analog input to convert
// - all-passes-done raises interrupt when its enable bit is 1
package adsr_pkg;
	localparam logic [7:0] OFF_CTRL0 = 8'h00;
	localparam logic [7:0] OFF_CTRL2 = 8'h04;
	localparam logic [7:0] OFF_SLOTSEL = 8'h08;
	localparam logic [7:0] OFF_SLOTCH = 8'h0c;
	localparam logic [7:0] OFF_START = 8'h10;
	localparam logic [7:0] OFF_FSTAT = 8'h14;
	localparam logic [7:0] OFF_FCLR = 8'h18;
	localparam logic [7:0] OFF_IEN = 8'h1c;
	localparam logic [7:0] OFF_RES0 = 8'h20;
	localparam logic [7:0] OFF_SUM = 8'h40;
	localparam int CR0_EN = 0;
	localparam int CR0_MODE_LSB = 1;
	localparam int CR0_TRIG = 4;
	localparam int CR2_SUMEN = 8;
	localparam int CR2_SUMCLR = 9;
	localparam int FLG_READY = 0;
	localparam int FLG_EOC = 1;
	localparam int FLG_SEQ_DONE = 2;
	localparam int FLG_ALL_DONE = 3;
	localparam int FLG_OVR = 4;
	localparam logic [2:0] MODE_MULTI = 3'h5;
	localparam logic [2:0] MODE_STEP = 3'h6;
	localparam logic [4:0] CTRL0_RST = 5'h00;
	localparam logic [7:0] CNT_RST = 8'h00;
	localparam logic [2:0] SLOTSEL_RST = 3'h0;
	localparam logic [31:0] SLOTCH_RST = 32'h0000_0000;
	localparam logic [4:0] IEN_RST = 5'h00;
	localparam int STARTUP_NS = 1000;
	localparam int CLK_MHZ = 100;
	localparam logic [7:0] STARTUP_CYC = 8'((STARTUP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {S_IDLE = 2'b01, S_BUSY = 2'b10} adsr_state_t;
endpackage

// [logic/adsr_sync2.sv]
// Purpose: two flip-flop synchroniser for the external trigger pin
// Assumes: d is asynchronous to aclk
// Notes: first stage is read only by the second
`timescale 1ns/10ps
module adsr_sync2
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic d,
	output logic q
);
	logic meta_r;
	// plain double register, no logic between stages
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_r <= 1'b0;
			q <= 1'b0;
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // adsr_sync2

// [logic/adsr_top.sv]
// Purpose: sequencer for multi-pass (mode 5) and step (mode 6) conversion
// Assumes: converter core on aclk; one conv_done pulse per conv_start pulse
// Notes: other mode codes run one single scan of the selected slots
`timescale 1ns/10ps
module adsr_top
	import adsr_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic ext_trig,
	output logic conv_start,
	output logic [3:0] conv_chan,
	input wire logic conv_done,
	input wire logic [11:0] conv_data,
	output logic irq
);
	logic aw_held_r, w_held_r;
	logic [7:0] wa_r;
	logic [31:0] wd_r, wm_r;
	logic [4:0] ctrl0_r;
	logic [7:0] cnt_r;
	logic sumen_r;
	logic [2:0] slotsel_r;
	logic [31:0] slotch_r;
	logic [4:0] ien_r;
	logic start_r;
	logic [31:0] sum_r;
	logic [11:0] res_r [0:7];
	logic [7:0] unread_r;
	logic [2:0] slot_r;
	logic [7:0] pass_r;
	logic [7:0] warm_r;
	logic trig_s, trig_prev_r;
	adsr_state_t state_r;
	logic [4:1] flag_q;

	// write decode: fires once address and data are both held
	wire wr_fire = aw_held_r && w_held_r;
	wire wr_ctrl0 = wr_fire && (wa_r == OFF_CTRL0);
	wire wr_ctrl2 = wr_fire && (wa_r == OFF_CTRL2);
	wire wr_start = wr_fire && (wa_r == OFF_START) && wm_r[0];
	wire wr_fclr = wr_fire && (wa_r == OFF_FCLR);
	wire wr_ok = (wa_r <= OFF_IEN) || (wa_r == OFF_SUM) || (wa_r[7:5] == 3'b001);
	wire [31:0] m_ctrl0 = ({27'h0, ctrl0_r} & ~wm_r) | (wd_r & wm_r);
	wire [31:0] m_ctrl2 = ({23'h0, sumen_r, cnt_r} & ~wm_r) | (wd_r & wm_r);
	wire [31:0] m_slotsel = ({29'h0, slotsel_r} & ~wm_r) | (wd_r & wm_r);
	wire [31:0] m_slotch = (slotch_r & ~wm_r) | (wd_r & wm_r);
	wire [31:0] m_ien = ({27'h0, ien_r} & ~wm_r) | (wd_r & wm_r);
	wire sum_clr = wr_ctrl2 && wm_r[CR2_SUMCLR] && wd_r[CR2_SUMCLR];
	wire [4:1] flag_clr = {4{wr_fclr}} & wm_r[4:1] & ~wd_r[4:1];
	wire [3:0] strb_s = wvalid ? wstrb : 4'h0;
	wire [31:0] strb_mask = {{8{strb_s[3]}}, {8{strb_s[2]}}, {8{strb_s[1]}}, {8{strb_s[0]}}};

	// sequencing terms
	wire en = ctrl0_r[CR0_EN];
	wire [2:0] mode = ctrl0_r[CR0_MODE_LSB +: 3];
	wire is_multi = (mode == MODE_MULTI);
	wire is_step = (mode == MODE_STEP);
	wire ready = en && (warm_r == STARTUP_CYC);
	wire trig_rise = ctrl0_r[CR0_TRIG] && trig_s && !trig_prev_r;
	wire launch = (state_r == S_IDLE) && start_r && ready;
	wire done_hit = (state_r == S_BUSY) && conv_done;
	wire last = (slot_r == slotsel_r);
	wire passes_done = (pass_r == cnt_r);
	wire fin_all = done_hit && is_multi && last && passes_done;
	wire cont_mul = is_multi && !(last && passes_done);
	wire cont = done_hit && (cont_mul || (!is_multi && !is_step && !last));
	wire stop = done_hit && !cont;
	wire [2:0] slot_inc = 3'(slot_r + 3'h1);
	// step mode resumes at its pointer; other modes begin a run at slot 0
	wire [2:0] slot_go = launch ? (is_step ? slot_r : 3'h0) : (last ? 3'h0 : slot_inc);
	wire [3:0] chan_go = slotch_r[{slot_go, 2'b00} +: 4];
	wire [4:0] flags = {flag_q, ready};

	// read mux
	wire ar_res = (araddr[7:5] == 3'b001);
	wire ar_ok = (araddr <= OFF_IEN) || (araddr == OFF_SUM) || ar_res;
	wire [31:0] rd_word =
		ar_res ? {20'h0, res_r[araddr[4:2]]} :
		(araddr == OFF_CTRL0) ? {27'h0, ctrl0_r} :
		(araddr == OFF_CTRL2) ? {23'h0, sumen_r, cnt_r} :
		(araddr == OFF_SLOTSEL) ? {29'h0, slotsel_r} :
		(araddr == OFF_SLOTCH) ? slotch_r :
		(araddr == OFF_START) ? {31'h0, start_r} :
		(araddr == OFF_FSTAT) ? {27'h0, flags} :
		(araddr == OFF_IEN) ? {27'h0, ien_r} :
		(araddr == OFF_SUM) ? sum_r : 32'h0;
	wire rd_fire = arvalid && arready;
	wire [7:0] rd_clear = (rd_fire && ar_res) ? (8'h01 << araddr[4:2]) : 8'h00;

	adsr_sync2 u_trig_sync
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.d(ext_trig),
		.q(trig_s)
	);

	// sticky flags: conversion, pass, whole run and overflow
	genvar gi;
	generate
		for (gi = 1; gi < 5; gi = gi + 1)
		begin : g_flag
			wire fset = (gi == FLG_EOC) ? done_hit :
				(gi == FLG_SEQ_DONE) ? (done_hit && last) :
				(gi == FLG_ALL_DONE) ? fin_all : (done_hit && unread_r[slot_r]);
			adsr_flag u_flag
			(
				.aclk(aclk),
				.aresetn(aresetn),
				.set(fset),
				.clr(flag_clr[gi]),
				.q(flag_q[gi])
			);
		end
	endgenerate

	// write channel: address and data taken in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			wa_r <= 8'h00;
			wd_r <= 32'h0;
			wm_r <= 32'h0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OK;
		end
		else
		begin
			awready <= !aw_held_r && !(awvalid && awready) && !bvalid;
			wready <= !w_held_r && !(wvalid && wready) && !bvalid;
			if (awvalid && awready)
			begin
				aw_held_r <= 1'b1;
				wa_r <= {awaddr[7:2], 2'b00};
			end
			if (wvalid && wready)
			begin
				w_held_r <= 1'b1;
				wd_r <= wdata;
				wm_r <= strb_mask;
			end
			if (wr_fire)
			begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_ok ? RESP_OK : RESP_SLVERR;
				awready <= 1'b0;
				wready <= 1'b0;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	// read channel: one cycle from address to data
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= RESP_OK;
		end
		else if (rd_fire)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= ar_ok ? RESP_OK : RESP_SLVERR;
		end
		else if (rvalid && rready)
			rvalid <= 1'b0;
		else
			arready <= !rvalid;
	end

	// configuration registers; sum_clear is a strobe and is not stored
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl0_r <= CTRL0_RST;
			cnt_r <= CNT_RST;
			sumen_r <= 1'b0;
			slotsel_r <= SLOTSEL_RST;
			slotch_r <= SLOTCH_RST;
			ien_r <= IEN_RST;
		end
		else if (wr_fire)
		begin
			if (wr_ctrl0)
				ctrl0_r <= m_ctrl0[4:0];
			if (wr_ctrl2)
				{sumen_r, cnt_r} <= m_ctrl2[8:0];
			if (wa_r == OFF_SLOTSEL)
				slotsel_r <= m_slotsel[2:0];
			if (wa_r == OFF_SLOTCH)
				slotch_r <= m_slotch;
			if (wa_r == OFF_IEN)
				ien_r <= m_ien[4:0];
		end
	end

	// start bit: a software write in the same cycle beats the self-clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			start_r <= 1'b0;
		else if (wr_start)
			start_r <= wd_r[0];
		else if (!en)
			start_r <= 1'b0;
		else if (trig_rise && state_r == S_IDLE)
			start_r <= 1'b1;
		else if (stop)
			start_r <= 1'b0;
	end

	// warm-up counter drives the ready flag after enable
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !en)
			warm_r <= 8'h00;
		else if (warm_r != STARTUP_CYC)
			warm_r <= 8'(warm_r + 8'h01);
	end

	// sequencer state, slot pointer and pass counter
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r <= S_IDLE;
			slot_r <= 3'h0;
			pass_r <= 8'h00;
			conv_start <= 1'b0;
			conv_chan <= 4'h0;
			trig_prev_r <= 1'b0;
		end
		else
		begin
			trig_prev_r <= trig_s;
			conv_start <= launch || cont;
			if (launch || cont)
			begin
				slot_r <= slot_go;
				conv_chan <= chan_go;
			end
			else if (done_hit && is_step)
				slot_r <= slot_inc;
			if (launch)
				pass_r <= 8'h00;
			else if (done_hit && is_multi && last && !passes_done)
				pass_r <= 8'(pass_r + 8'h01);
			if (!en || stop)
				state_r <= S_IDLE;
			else if (launch)
				state_r <= S_BUSY;
		end
	end

	// results, unread tracking and accumulator; a read clears unread
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			unread_r <= 8'h00;
			sum_r <= 32'h0;
			for (int i = 0; i < 8; i++)
				res_r[i] <= 12'h000;
		end
		else
		begin
			unread_r <= (unread_r & ~rd_clear) | (done_hit ? (8'h01 << slot_r) : 8'h00);
			if (done_hit)
				res_r[slot_r] <= conv_data;
			if (sum_clr)
				sum_r <= 32'h0;
			else if (done_hit && sumen_r)
				sum_r <= 32'(sum_r + {20'h0, conv_data});
		end
	end

	// interrupt from enabled status bits
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= |(flags & ien_r);
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_fin;
		done_hit && is_multi && last && passes_done;
	endsequence
	sequence s_halt;
		!start_r && flag_q[FLG_ALL_DONE] && (state_r == S_IDLE);
	endsequence
	property p_alldone_stop;
		s_fin |=> s_halt;
	endproperty
	a_alldone_stop: assert property (p_alldone_stop) else $error("no stop at end");
	property p_multi_cont;
		(done_hit && cont_mul && en) |=> conv_start && (state_r == S_BUSY);
	endproperty
	a_multi_cont: assert property (p_multi_cont) else $error("pass stalled");
	property p_step_stop;
		(done_hit && is_step && !wr_start) |=> !start_r && !conv_start ##1 !conv_start;
	endproperty
	a_step_stop: assert property (p_step_stop) else $error("step kept going");
	property p_step_wrap;
		(done_hit && is_step && slot_r == 3'h7) |=> (slot_r == 3'h0);
	endproperty
	a_step_wrap: assert property (p_step_wrap) else $error("no wrap");
	property p_seqdone_cause;
		$rose(flag_q[FLG_SEQ_DONE]) |-> $past(done_hit && last);
	endproperty
	a_seqdone_cause: assert property (p_seqdone_cause) else $error("early pass done");
	property p_store;
		done_hit |=> (res_r[$past(slot_r)] == $past(conv_data)) && flag_q[FLG_EOC];
	endproperty
	a_store: assert property (p_store) else $error("result lost");
	property p_sum;
		(done_hit && sumen_r && !sum_clr) |=> sum_r == 32'($past(sum_r) + $past(conv_data));
	endproperty
	a_sum: assert property (p_sum) else $error("sum wrong");
	property p_pass_cnt;
		$rose(flag_q[FLG_ALL_DONE]) |-> $past(pass_r) == $past(cnt_r);
	endproperty
	a_pass_cnt: assert property (p_pass_cnt) else $error("pass count wrong");
	property p_first;
		(launch && is_multi) |=> conv_start && slot_r == 3'h0 && pass_r == 8'h00;
	endproperty
	a_first: assert property (p_first) else $error("run not from slot 0");
	property p_chan;
		conv_start |-> conv_chan == slotch_r[{slot_r, 2'b00} +: 4];
	endproperty
	a_chan: assert property (p_chan) else $error("wrong channel");
	property p_irq;
		(flag_q[FLG_ALL_DONE] && ien_r[FLG_ALL_DONE]) |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("no irq");
endmodule // adsr_top

// [tb/adsr_core_model.sv]
// Purpose: behavioural converter core that answers each conv_start with one conv_done
// Assumes: same clock as the sequencer, one conversion in flight at a time
// Notes: the result line toggles outside the done pulse so stale data is never mistaken
`timescale 1ns/10ps
module adsr_core_model
(
	input wire logic aclk,
	input wire logic conv_start,
	input wire logic [3:0] conv_chan,
	input wire logic slow,
	output logic conv_done,
	output logic [11:0] conv_data
);
	int wait_c = -1;
	logic [3:0] chan_r = 4'h0;
	initial
	begin
		conv_done = 1'b0;
		conv_data = 12'h000;
	end
	// fixed result per input so the bench can predict it; slow mode stretches the wait
	always @(posedge aclk)
	begin
		conv_done <= 1'b0;
		conv_data <= ~conv_data;
		if (conv_start)
		begin
			chan_r <= conv_chan;
			wait_c <= slow ? 6 : 0;
		end
		else if (wait_c == 0)
		begin
			conv_done <= 1'b1;
			conv_data <= 12'h3a0 + 12'(chan_r);
			wait_c <= -1;
		end
		else if (wait_c > 0)
			wait_c <= wait_c - 1;
	end
endmodule // adsr_core_model

// [tb/adsr_tb.sv]
// Purpose: self-checking bench for the multi-pass and step sequencer
// Assumes: AXI4-Lite master tasks, behavioural core model on the converter link
// Notes: flag clears keep the ready bit at 1 so starts are not blocked
`timescale 1ns/10ps
module adc_sequence_repeat_and_step_control_tb;
	import adsr_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic ext_trig = 1'b0, slow = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, conv_start, conv_done, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [3:0] conv_chan;
	logic [11:0] conv_data;
	int n_mismatch = 0, checked = 0, cyc = 0;
	logic [3:0] seen[$];
	logic [7:0] rst_a[8] = '{OFF_CTRL0, OFF_CTRL2, OFF_SLOTSEL, OFF_SLOTCH, OFF_START,
		OFF_FSTAT, OFF_IEN, OFF_SUM};

	adsr_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.ext_trig(ext_trig), .conv_start(conv_start), .conv_chan(conv_chan),
		.conv_done(conv_done), .conv_data(conv_data), .irq(irq));
	adsr_core_model core (.aclk(aclk), .conv_start(conv_start), .conv_chan(conv_chan),
		.slow(slow), .conv_done(conv_done), .conv_data(conv_data));

	initial
	begin
		forever #5 aclk = ~aclk;
	end

	task automatic summarize();
		if (n_mismatch == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// conversion monitor and hang guard
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (conv_start)
			seen.push_back(conv_chan);
		if (cyc == 60000)
		begin
			n_mismatch++;
			summarize();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic [11:0] exp_data(input logic [3:0] ch);
		return 12'h3a0 + 12'(ch);
	endfunction

	// both items offered together; each released at its own handshake
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OK);
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hf;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while ((awvalid && !awready) || (wvalid && !wready));
		while (!bvalid)
			@(posedge aclk);
		bready <= 1'b0;
		chk(bresp, er);
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OK);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge aclk);
		while (!arready)
			@(posedge aclk);
		arvalid <= 1'b0;
		while (!rvalid)
			@(posedge aclk);
		d = rdata;
		rready <= 1'b0;
		chk(rresp, er);
	endtask

	task automatic poll(input logic [7:0] a, input int b, input logic v);
		logic [31:0] d;
		axr(a, d);
		while (d[b] !== v)
			axr(a, d);
	endtask

	initial
	begin
		logic [31:0] d, sum, ch;
		logic [2:0] sel, ptr;
		logic [7:0] cnt;
		int k;
		void'($urandom(32'hb32c));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		// reset values, then an unmapped place
		foreach (rst_a[i])
		begin
			axr(rst_a[i], d);
			chk(d, 32'h0);
		end
		axr(8'h80, d, RESP_SLVERR);
		chk(d, 32'h0);
		axw(8'h80, 32'hffff_ffff, RESP_SLVERR);
		axw(OFF_CTRL0, 32'h1);
		poll(OFF_FSTAT, FLG_READY, 1'b1);
		ch = $urandom();
		axw(OFF_SLOTCH, ch);
		// step mode: software and pin starts alternate, pointer crosses the wrap
		sel = 3'($urandom_range(7));
		axw(OFF_SLOTSEL, 32'(sel));
		axw(OFF_CTRL0, {27'h0, 1'b1, MODE_STEP, 1'b1});
		ptr = 3'h0;
		for (k = 0; k < 10; k++)
		begin
			axw(OFF_FCLR, ~32'h1e);
			seen.delete();
			if (k[0])
			begin
				ext_trig <= 1'b1;
				repeat (4) @(posedge aclk);
				ext_trig <= 1'b0;
			end
			else
				axw(OFF_START, 32'h1);
			poll(OFF_FSTAT, FLG_EOC, 1'b1);
			axr(OFF_FSTAT, d);
			chk(d[FLG_SEQ_DONE], ptr == sel);
			chk(seen.size(), 1);
			chk(seen[0], ch[4*ptr +: 4]);
			axr(OFF_RES0 + 8'(4 * ptr), d);
			chk(d, exp_data(ch[4*ptr +: 4]));
			axr(OFF_START, d);
			chk(d[0], 1'b0);
			ptr = ptr + 3'h1;
		end
		// multi-pass runs: single pass, the 10 case, a random count started from the pin
		axw(OFF_IEN, 32'h1 << FLG_ALL_DONE);
		for (k = 0; k < 3; k++)
		begin
			cnt = (k == 0) ? 8'h00 : (k == 1) ? 8'h0a : 8'($urandom_range(1, 3));
			sel = 3'($urandom_range(3));
			slow <= k[0];
			axw(OFF_CTRL0, {27'h0, (k == 2), MODE_MULTI, 1'b1});
			axw(OFF_SLOTSEL, 32'(sel));
			axw(OFF_CTRL2, {22'h0, 2'b11, cnt});
			axw(OFF_FCLR, ~32'h1e);
			repeat (2) @(posedge aclk);
			chk(irq, 1'b0);
			seen.delete();
			if (k == 2)
			begin
				ext_trig <= 1'b1;
				repeat (4) @(posedge aclk);
				ext_trig <= 1'b0;
			end
			else
				axw(OFF_START, 32'h1);
			poll(OFF_START, 0, 1'b0);
			chk(seen.size(), (cnt + 1) * (sel + 1));
			sum = 32'h0;
			foreach (seen[i])
			begin
				chk(seen[i], ch[4*(i % (sel + 1)) +: 4]);
				sum = sum + 32'(exp_data(ch[4*(i % (sel + 1)) +: 4]));
			end
			axr(OFF_SUM, d);
			chk(d, sum);
			axr(OFF_FSTAT, d);
			chk(d[4:1], {cnt != 8'h00, 3'b111});
			chk(irq, 1'b1);
			for (int i = 0; i <= sel; i++)
			begin
				axr(OFF_RES0 + 8'(4 * i), d);
				chk(d, exp_data(ch[4*i +: 4]));
			end
		end
		axw(OFF_CTRL0, 32'h0);
		summarize();
	end
endmodule // adc_sequence_repeat_and_step_control_tb
